// *** nic_power_state_aux_policy.v ***
// Power-state, auxiliary-power and gigabit policy with APB registers
// Function
// - PM disable bits from NVM; PM registers stay present and accessible.
// - APM wake enable lets wake output assert with PME enable clear.
// - States D0u, D0a, D3, plus power-loss state when power-good drops.
// - Advertise D3cold wake only if disable bit clear and aux present.
// - Reported power figure comes from nonvolatile memory fetch.
// - With D3cold support, PME enable/status cleared only by power-up reset.
// - Aux present only affects D3cold advertisement and PME reset behaviour.
// - Power-loss aux level chosen from PME enable and aux PM enable.
// - Compliance and aux PM enable set: higher aux power allowed in power-loss regardless.
// - Compliance set, aux PM enable clear: higher aux follows PME enable.
// - Compliance clear: aux power drawn in power-loss regardless.
// - Gigabit-disable bit blocks 1000 Mb/s everywhere.
// - Non-D0a gigabit disable withdraws advert, renegotiates if at gigabit.
// - Restart auto-negotiation whenever gigabit permission changes.
`timescale 1ns/10ps
`include "pm_policy_map.vh"
module nic_power_state_aux_policy #(
   parameter ANEG_CYCLES = `ANEG_CYC
) (
   // Clock and resets
   input  wire        pclk,
   input  wire        presetn,
   input  wire        power_up_rst_n,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Platform power
   input  wire        lan_power_ok,
   input  wire        aux_power_present,
   // Nonvolatile fetch
   input  wire        nvm_load,
   input  wire [12:0] nvm_data,
   // Wake event
   input  wire        wake_event,
   // Policy outputs
   output reg  [1:0]  power_state_q,
   output reg         wake_out_n,
   output reg         d3cold_wake_adv_q,
   output reg         aux_high_power_q,
   output reg         gig_advertise_q,
   output reg         aneg_restart_q,
   output reg         irq
);

   // =====================================================================
   // Nonvolatile configuration latch
   // Bits 4:0 are policy switches, bits 12:5 the reported power figure
   // Nothing here reacts to the ordinary reset, so policy survives it
   wire [12:0] nvm_q;
   wire        nvm_loaded;
   // Loader restarts only with power-up reset so values persist over others
   pm_nvm_latch #(.W(13)) u_nvm (
      .pclk      (pclk),
      .presetn   (power_up_rst_n),
      .load      (nvm_load),
      .load_data (nvm_data),
      .held_q    (nvm_q),
      .loaded_q  (nvm_loaded)
   );

   wire       pm_disable         = nvm_q[`NVM_PM_DIS];
   wire       d3cold_wake_disable = nvm_q[`NVM_D3C_DIS];
   wire       aux_regime         = nvm_q[`NVM_AUX_REG];
   wire       gig_disable        = nvm_q[`NVM_GIG_DIS];
   wire       gig_dis_nd0a       = nvm_q[`NVM_GIG_ND0A];
   wire [7:0] pm_data            = nvm_q[12:5];

   // =====================================================================
   // APB decode
   wire wr_en = psel && penable && pwrite;
   wire rd_en = psel && !pwrite;

   function is_mapped;
      input [7:0] a;
      begin
         if (a == `REG_CTRL) begin
            is_mapped = 1'b1;
         end else if (a == `REG_PMCSR) begin
            is_mapped = 1'b1;
         end else if (a == `REG_WAKE_CTRL) begin
            is_mapped = 1'b1;
         end else if (a == `REG_NVM_CFG) begin
            is_mapped = 1'b1;
         end else if (a == `REG_STATUS) begin
            is_mapped = 1'b1;
         end else if (a == `REG_IRQ_STATUS) begin
            is_mapped = 1'b1;
         end else if (a == `REG_IRQ_ENABLE) begin
            is_mapped = 1'b1;
         end else if (a == `REG_IRQ_CLEAR) begin
            is_mapped = 1'b1;
         end else if (a == `REG_PM_DATA) begin
            is_mapped = 1'b1;
         end else begin
            is_mapped = 1'b0;
         end
      end
   endfunction

   // Zero-wait slave; unmapped addresses flag an error
   // No wait states: every access ends at the first access-phase edge
   // Misaligned or out-of-range offsets report an error and do nothing
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !is_mapped(paddr);

   // =====================================================================
   // Control register: driver requests and host config mirror
   reg [3:0] ctrl_q;
   // Bit 2 mirrors the host aux power PM enable; bit 3 reports gigabit link
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RST;
      end else if (wr_en && paddr == `REG_CTRL) begin
         ctrl_q <= pwdata[3:0];
      end
   end
   wire d3_req     = ctrl_q[`CTRL_D3_REQ];
   wire drv_active = ctrl_q[`CTRL_DRV_ACT];
   wire auxpm_en   = ctrl_q[`CTRL_AUXPM_EN];
   wire link_gig   = ctrl_q[`CTRL_LINK_GIG];

   // APM wake enable lives in the ordinary reset domain
   reg apm_wake_pme_enable;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apm_wake_pme_enable <= 1'b0;
      end else if (wr_en && paddr == `REG_WAKE_CTRL) begin
         apm_wake_pme_enable <= pwdata[`WAKE_APM_EN];
      end
   end

   // =====================================================================
   // PME enable and status with selectable reset
   // With D3cold support only power-up reset clears them, else either reset
   // Selector uses the power-up-domain bit and the pin directly; the advert
   // flop clears on the ordinary reset and so cannot be allowed to steer it
   wire d3c_support = !d3cold_wake_disable && aux_power_present;
   wire pme_rst_n   = d3c_support ? power_up_rst_n : (power_up_rst_n & presetn);
   reg  pme_en_q;
   reg  pme_sts_q;
   wire pme_wr_pmcsr = wr_en && paddr == `REG_PMCSR;
   wire pme_wr_wake  = wr_en && paddr == `REG_WAKE_CTRL;
   // Registers stay writable even when PM support is disabled
   // Either register view writes the enable; PMCSR wins if both were hit
   // A disabled PM function never raises status from a wake event
   always @(posedge pclk or negedge pme_rst_n) begin
      if (!pme_rst_n) begin
         pme_en_q  <= 1'b0;
         pme_sts_q <= 1'b0;
      end else begin
         if (pme_wr_pmcsr) begin
            pme_en_q <= pwdata[`PMCSR_PME_EN];
         end else if (pme_wr_wake) begin
            pme_en_q <= pwdata[`WAKE_PME_EN];
         end
         // Set wins over write-one-to-clear
         if (wake_event && !pm_disable) begin
            pme_sts_q <= 1'b1;
         end else if ((pme_wr_pmcsr && pwdata[`PMCSR_PME_STS]) ||
                      (pme_wr_wake && pwdata[`WAKE_PME_STS])) begin
            pme_sts_q <= 1'b0;
         end
      end
   end

   // =====================================================================
   // Power-state machine
   // D3 exit always passes through D0u; D0a needs the driver-active bit
   // Power loss overrides every state and is left only via D0u
   reg [1:0] state_d;
   // Next state from supply and driver requests
   always @* begin
      state_d = power_state_q;
      if (!lan_power_ok) begin
         state_d = `ST_DR;
      end else begin
         case (power_state_q)
            `ST_DR:  state_d = `ST_D0U;
            `ST_D0U: if (d3_req) state_d = `ST_D3;
                     else if (drv_active) state_d = `ST_D0A;
            `ST_D0A: if (d3_req) state_d = `ST_D3;
                     else if (!drv_active) state_d = `ST_D0U;
            `ST_D3:  if (!d3_req) state_d = `ST_D0U;
            default: state_d = `ST_D0U;
         endcase
      end
   end

   // State register; reset lands in power loss until supply is seen
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_state_q <= `ST_DR;
      end else begin
         power_state_q <= state_d;
      end
   end

   // =====================================================================
   // Gigabit permission
   // Judged for the current and the next state so that a restart
   // is raised at the same edge that changes the state
   function gig_ok;
      input [1:0] st;
      input       dis_all;
      input       dis_nd0a;
      begin
         gig_ok = !dis_all && !(dis_nd0a && st != `ST_D0A);
      end
   endfunction

   wire gig_now  = gig_ok(power_state_q, gig_disable, gig_dis_nd0a);
   wire gig_next = gig_ok(state_d, gig_disable, gig_dis_nd0a);
   // Permission flip, or leaving D0a while linked at gigabit
   wire aneg_evt = (gig_now != gig_next) ||
                   (gig_dis_nd0a && link_gig && power_state_q == `ST_D0A && state_d != `ST_D0A);

   // Hold restart high long enough for the PHY to see it
   // A new event while the pulse runs reloads the count and stretches it
   // Quiet until the fetch lands, as policy is unknown before that
   reg [7:0] aneg_cnt_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aneg_cnt_q      <= 8'h00;
         aneg_restart_q  <= 1'b0;
         gig_advertise_q <= 1'b0;
      end else begin
         gig_advertise_q <= gig_next;
         if (aneg_evt && nvm_loaded) begin
            aneg_cnt_q     <= ANEG_CYCLES[7:0];
            aneg_restart_q <= 1'b1;
         end else if (aneg_cnt_q > 8'h01) begin
            aneg_cnt_q <= aneg_cnt_q - 8'h01;
         end else begin
            aneg_cnt_q     <= 8'h00;
            aneg_restart_q <= 1'b0;
         end
      end
   end

   // =====================================================================
   // Aux power policy and wake output
   // Higher aux draw is only granted in the power-loss state; in the
   // powered states the main supply carries the load
   // Wake asserts for pending status with PME enable or APM wake enable
   reg aux_d;
   // Draw permission by regime bit, aux PM enable and PME enable
   always @* begin
      if (power_state_q != `ST_DR) begin
         aux_d = 1'b0;
      end else if (!aux_regime) begin
         aux_d = 1'b1;
      end else if (auxpm_en) begin
         aux_d = 1'b1;
      end else begin
         aux_d = pme_en_q;
      end
   end

   // Registered policy outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_high_power_q  <= 1'b0;
         d3cold_wake_adv_q <= 1'b0;
         wake_out_n        <= 1'b1;
      end else begin
         aux_high_power_q  <= aux_d;
         d3cold_wake_adv_q <= !d3cold_wake_disable && aux_power_present;
         wake_out_n        <= !(pme_sts_q && (pme_en_q || apm_wake_pme_enable));
      end
   end

   // =====================================================================
   // Interrupt status, enable, clear
   // Bit 0 any state change, bit 1 a restart, bit 2 entry to power loss
   // Output is registered from the next status so it tracks with no gap
   reg [`IRQ_W-1:0] irq_sts_q;
   reg [`IRQ_W-1:0] irq_en_q;
   wire [`IRQ_W-1:0] irq_set = {power_state_q != `ST_DR && state_d == `ST_DR,
                                aneg_evt && nvm_loaded,
                                power_state_q != state_d};
   wire [`IRQ_W-1:0] irq_clr = (wr_en && paddr == `REG_IRQ_CLEAR) ? pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
   // Set has priority so no event is lost on a clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sts_q <= {`IRQ_W{1'b0}};
         irq_en_q  <= {`IRQ_W{1'b0}};
         irq       <= 1'b0;
      end else begin
         irq_sts_q <= irq_set | (irq_sts_q & ~irq_clr);
         if (wr_en && paddr == `REG_IRQ_ENABLE) begin
            irq_en_q <= pwdata[`IRQ_W-1:0];
         end
         irq <= |((irq_set | (irq_sts_q & ~irq_clr)) & irq_en_q);
      end
   end

   // =====================================================================
   // Read mux
   // Reads have no side effects; status bits clear only on writes
   // Data is driven only while selected for a read, zero otherwise
   // Unmapped offsets read as zero
   always @* begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         if (paddr == `REG_CTRL) begin
            prdata[3:0] = ctrl_q;
         end else if (paddr == `REG_PMCSR) begin
            prdata[`PMCSR_PME_EN]  = pme_en_q;
            prdata[`PMCSR_PME_STS] = pme_sts_q;
         end else if (paddr == `REG_WAKE_CTRL) begin
            prdata[`WAKE_APM_EN]  = apm_wake_pme_enable;
            prdata[`WAKE_PME_EN]  = pme_en_q;
            prdata[`WAKE_PME_STS] = pme_sts_q;
            prdata[`WAKE_PME_EVT] = !wake_out_n;
         end else if (paddr == `REG_NVM_CFG) begin
            prdata[12:0] = nvm_q;
         end else if (paddr == `REG_STATUS) begin
            prdata[1:0] = power_state_q;
            prdata[2]   = d3cold_wake_adv_q;
            prdata[3]   = aux_high_power_q;
            prdata[4]   = gig_advertise_q;
            prdata[5]   = aneg_restart_q;
            prdata[6]   = nvm_loaded;
         end else if (paddr == `REG_IRQ_STATUS) begin
            prdata[`IRQ_W-1:0] = irq_sts_q;
         end else if (paddr == `REG_IRQ_ENABLE) begin
            prdata[`IRQ_W-1:0] = irq_en_q;
         end else if (paddr == `REG_PM_DATA) begin
            prdata[7:0] = pm_data;
         end
      end
   end

endmodule

// *** pm_policy_map.vh ***
// Register map, field positions, reset values and codes for the power-state policy block
`ifndef PM_POLICY_MAP_VH
`define PM_POLICY_MAP_VH

// =====================================================================
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_PMCSR       8'h04
`define REG_WAKE_CTRL   8'h08
`define REG_NVM_CFG     8'h0C
`define REG_STATUS      8'h10
`define REG_IRQ_STATUS  8'h14
`define REG_IRQ_ENABLE  8'h18
`define REG_IRQ_CLEAR   8'h1C
`define REG_PM_DATA     8'h20

// =====================================================================
// Field positions
`define CTRL_D3_REQ     0
`define CTRL_DRV_ACT    1
`define CTRL_AUXPM_EN   2
`define CTRL_LINK_GIG   3
`define PMCSR_PME_EN    8
`define PMCSR_PME_STS   15
`define WAKE_APM_EN     0
`define WAKE_PME_EN     1
`define WAKE_PME_STS    2
`define WAKE_PME_EVT    3
`define NVM_PM_DIS      0
`define NVM_D3C_DIS     1
`define NVM_AUX_REG     2
`define NVM_GIG_DIS     3
`define NVM_GIG_ND0A    4

// Interrupt bits
`define IRQ_STATE_CHG   0
`define IRQ_ANEG        1
`define IRQ_PWR_LOSS    2
`define IRQ_W           3

// =====================================================================
// Reset values
`define CTRL_RST        4'h0
`define WAKE_RST        2'h0
`define NVM_RST         5'h00
`define PM_DATA_RST     8'h00

// =====================================================================
// Power states
`define ST_D0U          2'h0
`define ST_D0A          2'h1
`define ST_D3           2'h2
`define ST_DR           2'h3

// Renegotiation pulse length
`define ANEG_PULSE_NS   100
`define ANEG_CYC        ((`ANEG_PULSE_NS + 9) / 10)

`endif

// *** pm_nvm_latch.v ***
// Latch for configuration fetched from nonvolatile memory
`timescale 1ns/10ps
module pm_nvm_latch #(
   parameter W = 13
) (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // Fetch side
   input  wire         load,
   input  wire [W-1:0] load_data,
   // Held copy
   output reg  [W-1:0] held_q,
   output reg          loaded_q
);

   // =====================================================================
   // Holding register
   // Capture only once per power-up so a later stray strobe cannot shift policy
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q   <= {W{1'b0}};
         loaded_q <= 1'b0;
      end else if (load && !loaded_q) begin
         held_q   <= load_data;
         loaded_q <= 1'b1;
      end
   end

endmodule

// *** plat_power_model.sv ***
// Platform power and nonvolatile fetch model beside the policy block
`timescale 1ns/10ps
module plat_power_model (
   // Clock and power-up reset
   input  wire        pclk,
   input  wire        power_up_rst_n,
   // Bench requests
   input  wire        pg_req,
   input  wire        aux_req,
   input  wire        refetch,
   input  wire [12:0] nvm_word,
   // Block side
   output reg         lan_power_ok,
   output reg         aux_power_present,
   output reg         nvm_load,
   output wire [12:0] nvm_data
);
   reg [2:0] cnt_q;
   // Data only valid with the strobe, so a late capture is caught
   assign nvm_data = nvm_load ? nvm_word : ~nvm_word;
   // Supplies follow the bench one edge late
   always @(posedge pclk) begin
      lan_power_ok <= pg_req;
      aux_power_present <= aux_req;
   end
   // One fetch shortly after power-up, extra ones on request
   always @(posedge pclk or negedge power_up_rst_n) begin
      if (!power_up_rst_n) begin
         cnt_q <= 3'h0;
         nvm_load <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
         nvm_load <= (cnt_q == 3'h3) | refetch;
      end
   end
endmodule

// *** pm_policy_checker.sv ***
// Concurrent checks on the power policy block ports
`timescale 1ns/10ps
`include "pm_policy_map.vh"
module pm_policy_checker #(
   parameter ANEG_CYCLES = 2
) (
   // Clock and resets
   input wire        pclk,
   input wire        presetn,
   input wire        power_up_rst_n,
   // APB
   input wire        psel,
   input wire        penable,
   input wire [7:0]  paddr,
   input wire        pready,
   input wire        pslverr,
   // Platform and fetch
   input wire        lan_power_ok,
   input wire        aux_power_present,
   input wire        nvm_load,
   input wire [12:0] nvm_data,
   // Policy outputs
   input wire [1:0]  power_state_q,
   input wire        d3cold_wake_adv_q,
   input wire        aux_high_power_q,
   input wire        gig_advertise_q,
   input wire        aneg_restart_q
);
   reg  [12:0] nvm_c_q;
   reg         ld_c_q;
   reg  [7:0]  hi_cnt_q;
   wire        adv_exp = ld_c_q & ~nvm_c_q[`NVM_D3C_DIS] & aux_power_present;
   // ==========
   // Own copy of the first fetch after power-up
   always @(posedge pclk or negedge power_up_rst_n) begin
      if (!power_up_rst_n) begin
         nvm_c_q <= 13'h0000;
         ld_c_q <= 1'b0;
      end else if (nvm_load && !ld_c_q) begin
         nvm_c_q <= nvm_data;
         ld_c_q <= 1'b1;
      end
   end
   // Length of the running restart pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hi_cnt_q <= 8'h00;
      else
         hi_cnt_q <= aneg_restart_q ? hi_cnt_q + 8'h01 : 8'h00;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Permission flip well clear of a reset
   sequence s_gig_flip;
      ld_c_q && $past(ld_c_q, 2) && $past(presetn, 2) && $changed(gig_advertise_q);
   endsequence
   sequence s_restart;
      ##[0:3] aneg_restart_q;
   endsequence
   a_ready_always: assert property (psel |-> pready)
      else $error("pready low in a transfer");
   a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
      |-> pslverr == (paddr > `REG_PM_DATA)) else $error("pslverr wrong");
   a_loss_to_dr: assert property (!lan_power_ok |=> power_state_q == `ST_DR)
      else $error("no power-loss state");
   a_adv_follow: assert property (ld_c_q && $past(ld_c_q) && $past(presetn)
      |-> d3cold_wake_adv_q == $past(adv_exp)) else $error("wake advert wrong");
   a_aux_dr_only: assert property ((power_state_q != `ST_DR)[*2] |-> !aux_high_power_q)
      else $error("aux draw outside power loss");
   a_gig_block: assert property ((ld_c_q && nvm_c_q[`NVM_GIG_DIS])[*3] |-> !gig_advertise_q)
      else $error("gigabit not blocked");
   a_aneg_len: assert property ($fell(aneg_restart_q) |-> hi_cnt_q == ANEG_CYCLES)
      else $error("restart pulse length wrong");
   a_aneg_on_flip: assert property (s_gig_flip |-> s_restart)
      else $error("no restart on permission change");
endmodule
bind nic_power_state_aux_policy pm_policy_checker #(.ANEG_CYCLES(ANEG_CYCLES)) u_pm_policy_checker (
   .pclk(pclk), .presetn(presetn), .power_up_rst_n(power_up_rst_n), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .lan_power_ok(lan_power_ok),
   .aux_power_present(aux_power_present), .nvm_load(nvm_load), .nvm_data(nvm_data),
   .power_state_q(power_state_q), .d3cold_wake_adv_q(d3cold_wake_adv_q),
   .aux_high_power_q(aux_high_power_q), .gig_advertise_q(gig_advertise_q), .aneg_restart_q(aneg_restart_q));

// *** tb_top.sv ***
// Self-checking bench for the power policy block
`timescale 1ns/10ps
`include "pm_policy_map.vh"
module tb_top;
   // ==========
   // Bench signals
   reg         pclk, presetn, power_up_rst_n, psel, penable, pwrite;
   reg         wake_event, pg_req, aux_req, refetch, err, seen;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, rd;
   reg  [12:0] nvm_word;
   reg  [3:0]  aux_tab [0:3];
   wire        pready, pslverr, lan_power_ok, aux_power_present, nvm_load, wake_out_n;
   wire        d3cold_wake_adv_q, aux_high_power_q, gig_advertise_q, aneg_restart_q, irq;
   wire [31:0] prdata;
   wire [12:0] nvm_data;
   wire [1:0]  power_state_q;
   integer     fail_count, checked, k;
   // Short restart pulse keeps the run brief
   nic_power_state_aux_policy #(.ANEG_CYCLES(2)) u_nic_power_state_aux_policy (
      .pclk(pclk), .presetn(presetn), .power_up_rst_n(power_up_rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .lan_power_ok(lan_power_ok),
      .aux_power_present(aux_power_present), .nvm_load(nvm_load), .nvm_data(nvm_data),
      .wake_event(wake_event), .power_state_q(power_state_q), .wake_out_n(wake_out_n),
      .d3cold_wake_adv_q(d3cold_wake_adv_q), .aux_high_power_q(aux_high_power_q),
      .gig_advertise_q(gig_advertise_q), .aneg_restart_q(aneg_restart_q), .irq(irq));
   plat_power_model u_plat_power_model (
      .pclk(pclk), .power_up_rst_n(power_up_rst_n), .pg_req(pg_req), .aux_req(aux_req),
      .refetch(refetch), .nvm_word(nvm_word), .lan_power_ok(lan_power_ok),
      .aux_power_present(aux_power_present), .nvm_load(nvm_load), .nvm_data(nvm_data));
   // Clock
   always #5 pclk = ~pclk;
   // ==========
   // Shared tasks
   task cyc(input integer n);
      repeat (n) @(posedge pclk);
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   // One APB transfer; data and error taken at the ready edge
   task apb(input [7:0] a, input w, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Power-up: both resets for five cycles, then the fetch lands
   task por(input [12:0] w);
      begin
         nvm_word <= w;
         presetn <= 1'b0;
         power_up_rst_n <= 1'b0;
         cyc(5);
         presetn <= 1'b1;
         power_up_rst_n <= 1'b1;
         cyc(10);
      end
   endtask
   task see_aneg;
      begin
         seen = 1'b0;
         repeat (8) begin
            @(posedge pclk);
            if (aneg_restart_q === 1'b1) seen = 1'b1;
         end
      end
   endtask
   task stop_test;
      begin
         if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // ==========
   // Scenarios
   task t_boot;
      begin
         chk(power_state_q, `ST_D0U);
         apb(`REG_PM_DATA, 1'b0, 32'h0);
         chk(rd, 32'hA5);
         nvm_word <= 13'h0F0F;
         refetch <= 1'b1;
         cyc(1);
         refetch <= 1'b0;
         cyc(3);
         apb(`REG_NVM_CFG, 1'b0, 32'h0);
         chk(rd, 32'h14B0);
         apb(8'h24, 1'b0, 32'h0);
         chk(err, 1'b1);
         chk(rd, 32'h0);
         aux_req <= 1'b1;
         cyc(4);
         chk(d3cold_wake_adv_q, 1'b1);
         aux_req <= 1'b0;
         cyc(4);
         chk(d3cold_wake_adv_q, 1'b0);
      end
   endtask
   task t_wake;
      begin
         wake_event <= 1'b1;
         cyc(1);
         wake_event <= 1'b0;
         cyc(3);
         chk(wake_out_n, 1'b1);
         apb(`REG_WAKE_CTRL, 1'b1, 32'h1);
         apb(`REG_PMCSR, 1'b0, 32'h0);
         chk({wake_out_n, rd[8]}, 2'b00);
         apb(`REG_WAKE_CTRL, 1'b1, 32'h5);
         cyc(3);
         chk(wake_out_n, 1'b1);
      end
   endtask
   // Ordinary reset keeps PME enable only while aux power is present
   task t_keep;
      for (k = 0; k < 2; k = k + 1) begin
         aux_req <= (k == 0);
         cyc(4);
         apb(`REG_PMCSR, 1'b1, 32'h100);
         presetn <= 1'b0;
         cyc(2);
         presetn <= 1'b1;
         cyc(2);
         apb(`REG_PMCSR, 1'b0, 32'h0);
         chk(rd & 32'h100, (k == 0) ? 32'h100 : 32'h0);
      end
   endtask
   // Table: regime bit, aux PM enable, PME enable, expected draw
   task t_aux;
      for (k = 0; k < 4; k = k + 1) begin
         por({8'hA5, 2'b00, aux_tab[k][3], 2'b00});
         apb(`REG_IRQ_ENABLE, 1'b1, 32'h4);
         apb(`REG_CTRL, 1'b1, {29'h0, aux_tab[k][2], 2'b00});
         apb(`REG_PMCSR, 1'b1, {23'h0, aux_tab[k][1], 8'h00});
         pg_req <= 1'b0;
         cyc(4);
         chk(power_state_q, `ST_DR);
         chk({aux_high_power_q, irq}, {aux_tab[k][0], 1'b1});
         pg_req <= 1'b1;
         apb(`REG_IRQ_ENABLE, 1'b1, 32'h0);
         cyc(2);
         chk(irq, 1'b0);
         apb(`REG_IRQ_CLEAR, 1'b1, 32'h4);
         apb(`REG_IRQ_ENABLE, 1'b1, 32'h4);
         cyc(2);
         chk(irq, 1'b0);
      end
   endtask
   task t_gig;
      begin
         por(13'h14B0);
         apb(`REG_CTRL, 1'b1, 32'hA);
         cyc(4);
         chk({power_state_q, gig_advertise_q}, {`ST_D0A, 1'b1});
         apb(`REG_CTRL, 1'b1, 32'h9);
         see_aneg;
         chk({seen, gig_advertise_q, power_state_q}, {2'b10, `ST_D3});
         apb(`REG_CTRL, 1'b1, 32'hA);
         see_aneg;
         chk({seen, gig_advertise_q}, 2'b11);
         // PM switched off by the fetch; its registers must still work
         por(13'h14A9);
         apb(`REG_PMCSR, 1'b1, 32'h100);
         apb(`REG_PMCSR, 1'b0, 32'h0);
         chk(rd, 32'h100);
         apb(`REG_CTRL, 1'b1, 32'hA);
         cyc(4);
         chk(gig_advertise_q, 1'b0);
      end
   endtask
   // ==========
   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      power_up_rst_n = 1'b0;
      {psel, penable, pwrite, wake_event, aux_req, refetch} = 6'h00;
      pg_req = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      nvm_word = 13'h14B0;
      fail_count = 0;
      checked = 0;
      aux_tab[0] = 4'h1;
      aux_tab[1] = 4'hD;
      aux_tab[2] = 4'h8;
      aux_tab[3] = 4'hB;
      por(13'h14B0);
      t_boot;
      t_wake;
      t_keep;
      t_aux;
      t_gig;
      stop_test;
   end
   // Watchdog well beyond the expected run
   initial begin
      #100000;
      fail_count = fail_count + 1;
      stop_test;
   end
endmodule
